// *** pressure_temp_i2c_readout_tb_top.sv ***
`timescale 1ns/1ps
`include "ptsense_regs.svh"
module pressure_temp_i2c_readout_tb_top;
  // Three conversion steps plus the one-cycle write
  localparam int MEAS_CYCLES = 3 * `STEP_CYCLES + 1;
  // Shortened start-up keeps the run brief
  localparam int BOOT_CYCLES = 2000;
  logic        clk;
  logic        rst;
  logic [6:0]  addr_cfg;
  logic        addr_cfg_we;
  logic [13:0] press_raw;
  logic [10:0] temp_raw;
  logic        ready;
  logic        busy;
  logic [6:0]  addr;
  logic        meas_req;
  logic        fetch_req;
  logic [2:0]  fetch_len;
  logic        done;
  logic        acked;
  logic [31:0] data;
  logic [6:0]  edge_addr [2] = '{7'h7F, 7'h00};
  int          n_errors = 0;
  int          samples_checked = 0;
  int          busy_cycles = 0;
  ptsense_if u_if ();
  // Pull-ups: a wire is low whenever any party pulls it
  assign u_if.scl_in = u_if.scl_oe_n | u_if.scl_out;
  assign u_if.serial_data_line_in =
    (u_if.serial_data_line_ctl_oe_n | u_if.serial_data_line_ctl_out)
    & (u_if.serial_data_line_tgt_oe_n | u_if.serial_data_line_tgt_out);
  ptsense_target #(.BOOT_CYCLES(BOOT_CYCLES)) u_ptsense_target (.CLK_SYS_IN(clk),
    .RST_IN(rst), .bus(u_if),
    .ADDR_CFG_IN(addr_cfg), .ADDR_CFG_WE_IN(addr_cfg_we), .PRESS_RAW_IN(press_raw),
    .TEMP_RAW_IN(temp_raw), .READY_OUT(ready), .BUSY_OUT(busy));
  ptsense_controller u_ptsense_controller (.CLK_SYS_IN(clk), .RST_IN(rst), .bus(u_if),
    .ADDR_IN(addr), .MEAS_REQ_IN(meas_req), .FETCH_REQ_IN(fetch_req),
    .FETCH_LEN_IN(fetch_len), .DONE_OUT(done), .ACKED_OUT(acked), .DATA_OUT(data));
  ptsense_props u_ptsense_props (.CLK_SYS_IN(clk), .RST_IN(rst), .scl_out(u_if.scl_out),
    .scl_oe_n(u_if.scl_oe_n), .serial_data_line_ctl_out(u_if.serial_data_line_ctl_out),
    .serial_data_line_ctl_oe_n(u_if.serial_data_line_ctl_oe_n),
    .serial_data_line_tgt_out(u_if.serial_data_line_tgt_out),
    .serial_data_line_tgt_oe_n(u_if.serial_data_line_tgt_oe_n),
    .scl_in(u_if.scl_in), .serial_data_line_in(u_if.serial_data_line_in));
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // Length of every measuring cycle, summed
  always @(posedge clk) if (busy === 1'b1) busy_cycles++;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One command through the controller; a missing done counts as a mismatch
  task automatic xfer(input logic [6:0] a, input logic m, input logic [2:0] len);
    addr = a;
    meas_req = m;
    fetch_req = ~m;
    fetch_len = len;
    @(posedge clk);
    #1;
    meas_req = 1'b0;
    fetch_req = 1'b0;
    for (int i = 0; i < 40000; i++) begin
      @(posedge clk);
      #1;
      if (done === 1'b1) break;
    end
    chk({31'h0, done}, 32'h1);
  endtask
  task automatic cfg_addr(input logic [6:0] a);
    addr_cfg = a;
    addr_cfg_we = 1'b1;
    @(posedge clk);
    #1;
    addr_cfg_we = 1'b0;
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    addr_cfg = `TGT_ADDR_DEFAULT;
    addr_cfg_we = 1'b0;
    press_raw = 14'h2ABC;
    temp_raw = 11'h5A3;
    addr = 7'h28;
    meas_req = 1'b0;
    fetch_req = 1'b0;
    fetch_len = 3'h1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    // Ready exactly when start-up ends; no command goes out before that
    chk({31'h0, ready}, 32'h0);
    chk({31'h0, busy}, 32'h0);
    repeat (BOOT_CYCLES - 1) @(posedge clk);
    #1;
    chk({31'h0, ready}, 32'h0);
    @(posedge clk);
    #1;
    chk({31'h0, ready}, 32'h1);
    xfer(7'h28, 1'b0, 3'h2);
    chk({30'h0, data[15:14]}, 32'h1);
    chk(busy_cycles, 32'h0);
    // Raw inputs move mid pressure step: old temperature, new pressure
    fork
      xfer(7'h28, 1'b1, 3'h1);
      begin
        wait (busy === 1'b1);
        repeat (96) @(posedge clk);
        #1;
        press_raw = 14'h1357;
        temp_raw = 11'h2C4;
      end
    join
    chk({31'h0, acked}, 32'h1);
    chk(busy_cycles, MEAS_CYCLES);
    xfer(7'h28, 1'b0, 3'h4);
    chk(data, {2'b00, 14'h1357, 11'h5A3, 5'h00});
    xfer(7'h28, 1'b0, 3'h2);
    chk({16'h0, data[15:0]}, {16'h0, 2'b01, 14'h1357});
    // Foreign address: no answer to either command
    xfer(7'h29, 1'b0, 3'h1);
    chk({31'h0, acked}, 32'h0);
    xfer(7'h29, 1'b1, 3'h1);
    chk({31'h0, acked}, 32'h0);
    // Both ends of the address range, default address 28 refused afterwards
    foreach (edge_addr[k]) begin
      cfg_addr(edge_addr[k]);
      xfer(7'h28, 1'b1, 3'h1);
      chk({31'h0, acked}, 32'h0);
      xfer(edge_addr[k], 1'b1, 3'h1);
      chk({31'h0, acked}, 32'h1);
      xfer(edge_addr[k], 1'b0, 3'h1);
      chk({24'h0, data[7:0]}, {24'h0, 2'b00, 6'h13});
    end
    chk(busy_cycles, 3 * MEAS_CYCLES);
    print_verdict();
  end
  // Watchdog sized for start-up plus all frames, with margin
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
endmodule

// *** ptsense_controller.sv ***
`timescale 1ns/1ps
`include "ptsense_regs.svh"
module ptsense_controller (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  ptsense_if.controller    bus,
  input  wire logic [6:0]  ADDR_IN,
  input  wire logic        MEAS_REQ_IN,
  input  wire logic        FETCH_REQ_IN,
  input  wire logic [2:0]  FETCH_LEN_IN,
  output logic             DONE_OUT,
  output logic             ACKED_OUT,
  output logic [31:0]      DATA_OUT
);
  import ptsense_pkg::*;

  ctl_state_t  st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [5:0]  idx_q, idx_d;
  logic [5:0]  last_q, last_d;
  logic [8:0]  tx_q, tx_d;
  logic [31:0] rx_q, rx_d;
  logic        rd_q, rd_d;
  logic        ack_q, ack_d;
  logic        scl_q, scl_d;
  logic        sda_q, sda_d;
  logic        done_d;
  logic [1:0]  sda_sync_q;
  // Bit position within a 9-bit slot
  wire [3:0]   slot = 4'(idx_q % 6'd9);
  wire         half_done = (cnt_q == `HALF_PERIOD - 1);

  // Data line sampled through two flops
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) sda_sync_q <= 2'h3;
    else sda_sync_q <= {sda_sync_q[0], bus.serial_data_line_in};
  end

  // Bit sequencer; one request at a time, start only when idle
  always_comb begin
    st_d   = st_q;
    cnt_d  = half_done ? 16'h0 : cnt_q + 16'h1;
    idx_d  = idx_q;
    last_d = last_q;
    tx_d   = tx_q;
    rx_d   = rx_q;
    rd_d   = rd_q;
    ack_d  = ack_q;
    scl_d  = scl_q;
    sda_d  = sda_q;
    done_d = 1'h0;
    case (st_q)
      CTL_IDLE: begin
        cnt_d = 16'h0;
        if (MEAS_REQ_IN || FETCH_REQ_IN) begin  // see R14
          rd_d   = ~MEAS_REQ_IN;  // see R16
          tx_d   = {ADDR_IN, ~MEAS_REQ_IN, 1'h1};
          last_d = MEAS_REQ_IN ? 6'd8 : 6'(9 * (FETCH_LEN_IN == 3'h0 ? 1 : FETCH_LEN_IN) + 8);
          idx_d  = 6'h0;
          rx_d   = 32'h0;
          ack_d  = 1'h0;
          sda_d  = 1'h0;  // Start: data falls while clock high
          st_d   = CTL_START;
        end
      end
      CTL_START: if (half_done) begin
        scl_d = 1'h0;
        st_d  = CTL_BIT_LO;
      end
      CTL_BIT_LO: if (half_done) begin
        scl_d = 1'h1;
        st_d  = CTL_BIT_HI;
      end else if (cnt_q == 16'h1) begin  // Drive after fall, see R4
        if (idx_q < 6'd9) sda_d = tx_q[8 - idx_q];
        else if (slot == 4'd8) sda_d = (idx_q == last_q);  // see R18
        else sda_d = 1'h1;
      end
      CTL_BIT_HI: if (half_done) begin  // see R5
        scl_d = 1'h0;
        if (idx_q == 6'd8) ack_d = ~sda_sync_q[1];
        else if (idx_q > 6'd8 && slot != 4'd8) rx_d = {rx_q[30:0], sda_sync_q[1]};
        if (idx_q == last_q || (idx_q == 6'd8 && sda_sync_q[1])) st_d = CTL_STOP_LO;  // see R15
        else begin
          idx_d = idx_q + 6'h1;
          st_d  = CTL_BIT_LO;
        end
      end
      CTL_STOP_LO: if (half_done) begin
        scl_d = 1'h1;
        st_d  = CTL_STOP_HI;
      end else if (cnt_q == 16'h1) sda_d = 1'h0;
      CTL_STOP_HI: if (half_done) begin
        sda_d = 1'h1;  // Stop: data rises while clock high
        st_d  = CTL_DONE;
      end
      CTL_DONE: if (half_done) begin
        done_d = 1'h1;
        st_d   = CTL_IDLE;
      end
      default: st_d = CTL_IDLE;
    endcase
  end

  // Registers; outputs straight from flops
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_q <= CTL_IDLE;
      cnt_q <= 16'h0;
      idx_q <= 6'h0;
      last_q <= 6'h0;
      tx_q <= 9'h0;
      rx_q <= 32'h0;
      rd_q <= 1'h0;
      ack_q <= 1'h0;
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      DONE_OUT <= 1'h0;
      ACKED_OUT <= 1'h0;
      DATA_OUT <= 32'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      last_q <= last_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      scl_q <= scl_d;
      sda_q <= sda_d;
      DONE_OUT <= done_d;
      if (done_d) ACKED_OUT <= ack_q;
      if (done_d) DATA_OUT <= rx_q;
    end
  end

  // Open drain drive; enable low while pulling low
  assign bus.scl_out = 1'h0;
  assign bus.scl_oe_n = scl_q;
  assign bus.serial_data_line_ctl_out = 1'h0;
  assign bus.serial_data_line_ctl_oe_n = sda_q;
endmodule

// *** ptsense_if.sv ***
`timescale 1ns/1ps
interface ptsense_if;
  logic scl_out;
  logic scl_oe_n;
  logic serial_data_line_ctl_out;
  logic serial_data_line_ctl_oe_n;
  logic serial_data_line_tgt_out;
  logic serial_data_line_tgt_oe_n;
  logic scl_in;
  logic serial_data_line_in;
  modport device (
    input  scl_in, serial_data_line_in,
    output serial_data_line_tgt_out, serial_data_line_tgt_oe_n
  );
  modport controller (
    input  scl_in, serial_data_line_in,
    output scl_out, scl_oe_n, serial_data_line_ctl_out, serial_data_line_ctl_oe_n
  );
endinterface

// *** ptsense_pkg.sv ***
package ptsense_pkg;
  typedef enum {
    TGT_IDLE, TGT_ADDR, TGT_ADDR_ACK, TGT_TX, TGT_TX_ACK, TGT_WAIT
  } tgt_state_t;
  typedef enum {
    MEAS_IDLE, MEAS_TEMP, MEAS_PRESS, MEAS_PROC, MEAS_WRITE
  } meas_state_t;
  typedef enum {
    CTL_IDLE, CTL_START, CTL_BIT_LO, CTL_BIT_HI, CTL_STOP_LO, CTL_STOP_HI, CTL_DONE
  } ctl_state_t;
endpackage

// *** ptsense_props.sv ***
`timescale 1ns/1ps
module ptsense_props (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic scl_out,
  input wire logic scl_oe_n,
  input wire logic serial_data_line_ctl_out,
  input wire logic serial_data_line_ctl_oe_n,
  input wire logic serial_data_line_tgt_out,
  input wire logic serial_data_line_tgt_oe_n,
  input wire logic scl_in,
  input wire logic serial_data_line_in
);
  localparam int T_MIN = 75;      // 0.6 us of 8 ns clocks
  localparam int FRAME_MAX = 32000;  // Address plus four bytes at the controller's rate, with margin
  logic        scl_q;
  logic        sda_q;
  logic        in_frame_q;
  logic [15:0] hold_q;
  logic [15:0] frame_q;
  wire start = scl_in & scl_q & sda_q & ~serial_data_line_in;
  wire stop  = scl_in & scl_q & ~sda_q & serial_data_line_in;
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (RST_IN);
  // Frame and level-width tracking; hold count saturates so a paused clock is harmless
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      in_frame_q <= 1'b0;
      hold_q     <= 16'hFFFF;
      frame_q    <= 16'h0000;
    end else begin
      scl_q      <= scl_in;
      sda_q      <= serial_data_line_in;
      in_frame_q <= start | (in_frame_q & ~stop);
      hold_q     <= (scl_in != scl_q) ? 16'h0000 : hold_q + {15'h0000, hold_q != 16'hFFFF};
      frame_q    <= in_frame_q ? frame_q + 16'h0001 : 16'h0000;
    end
  end
  a_tgt_moves_low: assert property (
    $changed(serial_data_line_tgt_oe_n) |-> !scl_in) else $error("target moved data, clock high");
  a_ctl_stable_high: assert property (
    in_frame_q && scl_in && $past(scl_in) && $changed(serial_data_line_ctl_oe_n)
    |-> serial_data_line_in) else $error("controller data moved while clock high");
  a_scl_high_min: assert property (
    $fell(scl_in) |-> hold_q >= T_MIN) else $error("clock high phase too short");
  a_scl_low_min: assert property (
    $rose(scl_in) |-> hold_q >= T_MIN) else $error("clock low phase too short");
  a_idle_released: assert property (
    !in_frame_q |-> serial_data_line_tgt_oe_n) else $error("target pulls outside a frame");
  a_idle_scl_high: assert property (
    !in_frame_q |-> scl_in) else $error("clock low outside a frame");
  a_open_drain: assert property (
    !scl_out && !serial_data_line_ctl_out && !serial_data_line_tgt_out)
    else $error("driver output not low");
  a_frame_bounded: assert property (
    frame_q < FRAME_MAX) else $error("frame too long");
  a_start_by_ctl: assert property (
    start |-> !serial_data_line_ctl_oe_n) else $error("start not made by controller");
  c_start: cover property (start);
  c_ack: cover property (in_frame_q && !serial_data_line_tgt_oe_n && $rose(scl_in));
  c_stop: cover property (stop);
endmodule

// *** ptsense_regs.svh ***
`ifndef PTSENSE_REGS_SVH
`define PTSENSE_REGS_SVH
// Default target address, changeable at run time
`define TGT_ADDR_DEFAULT 7'h28
// Start-up interval after reset
`define STARTUP_MS       10
`define CLK_HZ           125000000
`define STARTUP_CYCLES   ((`STARTUP_MS * (`CLK_HZ / 1000)))
// Length of each conversion step in system clocks
`define STEP_CYCLES      16'h0040
// Status codes
`define STAT_FRESH       2'h0
`define STAT_STALE       2'h1
// Bit count per byte on the wire
`define BYTE_BITS        4'h8
// Controller half-period in system clocks; just under the fast-mode bit rate
`define HALF_PERIOD      16'h009D
`endif

// *** ptsense_target.sv ***
`timescale 1ns/1ps
`include "ptsense_regs.svh"
// Function
// R1: Wait start-up interval before measurement-ready
// R2: Controller sends nothing during start-up
// R3: Static logic, any slow serial clock
// R4: Drive after falling edge, sample rising
// R5: Data stable while clock high
// R6: Works at standard and fast rates
// R7: Address defaults 28, fully reprogrammable
// R8: Only measure request and fetch
// R9: Fetch start snapshots packet into shifter
// R10: Output refresh deferred until transaction ends
// R11: Pressure always 14-bit
// R12: Idle until measure request, then cycle
// R13: Temperature, pressure, processing, then write
// R14: Measure request is address plus write
// R15: Acknowledge request; controller then stops
// R16: Fetch is address plus read, acknowledged
// R17: Status then 14-bit pressure, MSB first
// R18: Temperature bytes optional, NACK ends early
// R19: Status 00 fresh, 01 fetched
// R20: Sync lines, detect start/stop, match address
module ptsense_target #(parameter int BOOT_CYCLES = `STARTUP_CYCLES) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  ptsense_if.device        bus,
  input  wire logic [6:0]  ADDR_CFG_IN,
  input  wire logic        ADDR_CFG_WE_IN,
  input  wire logic [13:0] PRESS_RAW_IN,
  input  wire logic [10:0] TEMP_RAW_IN,
  output logic             READY_OUT,
  output logic             BUSY_OUT
);
  import ptsense_pkg::*;

  logic [1:0]  scl_sync_q, sda_sync_q;
  logic        scl_q, sda_q;
  tgt_state_t  st_q, st_d;
  meas_state_t ms_q, ms_d;
  logic [31:0] boot_q, boot_d;
  logic        ready_q, ready_d;
  logic [15:0] step_q, step_d;
  logic [6:0]  addr_q, addr_d;
  logic [7:0]  sh_q, sh_d;
  logic [3:0]  bit_q, bit_d;
  logic [1:0]  byte_q, byte_d;
  logic        rd_q, rd_d;
  logic        drv_q, drv_d;
  logic        dout_q, dout_d;
  logic [31:0] snap_q, snap_d;
  logic [13:0] press_q, press_d;
  logic [10:0] temp_q, temp_d;
  logic [1:0]  stat_q, stat_d;
  logic [13:0] pend_p_q, pend_p_d;
  logic [10:0] pend_t_q, pend_t_d;
  logic        pend_q, pend_d;
  logic        req_q, req_d;

  wire scl_rise  = scl_sync_q[1] & ~scl_q;  // see R6
  wire scl_fall  = ~scl_sync_q[1] & scl_q;
  wire start_det = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  wire stop_det  = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];
  wire in_xfer   = (st_q != TGT_IDLE);

  // Packet bit by byte index and position from the byte's MSB
  function automatic logic pkt_bit(logic [31:0] p, logic [1:0] i, logic [2:0] b);
    pkt_bit = p[31 - 8 * i - b];
  endfunction

  // Two-flop synchronisers; stage one feeds only stage two
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
    if (RST_IN) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'h1;
      sda_q      <= 1'h1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], bus.scl_in};  // see R20
      sda_sync_q <= {sda_sync_q[0], bus.serial_data_line_in};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end

  // Measurement sequencer and result register
  always_comb begin
    boot_d   = boot_q;
    ready_d  = ready_q;
    ms_d     = ms_q;
    step_d   = step_q;
    addr_d   = ADDR_CFG_WE_IN ? ADDR_CFG_IN : addr_q;  // see R7
    temp_d   = temp_q;
    press_d  = press_q;
    stat_d   = stat_q;
    pend_p_d = pend_p_q;
    pend_t_d = pend_t_q;
    pend_d   = pend_q;
    if (!ready_q) begin
      if (boot_q == 32'(BOOT_CYCLES - 1)) ready_d = 1'h1;  // see R1
      else boot_d = boot_q + 32'h1;
    end
    case (ms_q)
      MEAS_IDLE: begin
        step_d = 16'h0;
        if (req_q) ms_d = MEAS_TEMP;  // see R12
      end
      MEAS_TEMP, MEAS_PRESS, MEAS_PROC: begin
        step_d = step_q + 16'h1;
        if (step_q == `STEP_CYCLES - 1) begin
          step_d = 16'h0;
          if (ms_q == MEAS_TEMP) begin
            pend_t_d = TEMP_RAW_IN;  // see R13
            ms_d = MEAS_PRESS;
          end else if (ms_q == MEAS_PRESS) begin
            pend_p_d = PRESS_RAW_IN;  // see R11
            ms_d = MEAS_PROC;
          end else begin
            ms_d = MEAS_WRITE;
          end
        end
      end
      MEAS_WRITE: begin
        pend_d = 1'h1;
        ms_d   = MEAS_IDLE;
      end
      default: ms_d = MEAS_IDLE;
    endcase
    // Output refresh waits for the bus to go idle
    if (pend_q && !in_xfer) begin  // see R10
      press_d = pend_p_q;
      temp_d  = pend_t_q;
      stat_d  = `STAT_FRESH;  // see R19
      pend_d  = (ms_q == MEAS_WRITE);  // A result landing now stays pending
    end else if (st_q == TGT_TX && bit_q == 4'h0 && byte_q == 2'h0 && scl_fall) begin
      stat_d = `STAT_STALE;  // see R19
    end
  end

  // Bus engine
  always_comb begin
    st_d   = st_q;
    sh_d   = sh_q;
    bit_d  = bit_q;
    byte_d = byte_q;
    rd_d   = rd_q;
    drv_d  = drv_q;
    dout_d = dout_q;
    snap_d = snap_q;
    req_d  = 1'h0;
    if (stop_det) begin
      st_d  = TGT_IDLE;
      drv_d = 1'h0;
    end else if (start_det) begin  // see R20
      st_d  = TGT_ADDR;
      bit_d = 4'h0;
      drv_d = 1'h0;
    end else begin
      case (st_q)
        TGT_IDLE: drv_d = 1'h0;
        TGT_ADDR: if (scl_rise) begin  // see R4
          sh_d  = {sh_q[6:0], sda_q};
          bit_d = bit_q + 4'h1;
        end else if (scl_fall && bit_q == `BYTE_BITS) begin
          if (sh_q[7:1] == addr_q) begin  // see R20
            drv_d  = 1'h1;  // see R15
            dout_d = 1'h0;  // see R16
            rd_d   = sh_q[0];
            st_d   = TGT_ADDR_ACK;
            if (sh_q[0]) snap_d = {stat_q, press_q, temp_q, 5'h00};  // see R9
            else req_d = ready_q && ms_q == MEAS_IDLE;  // see R14
          end else begin
            st_d = TGT_WAIT;
          end
        end
        TGT_ADDR_ACK: if (scl_fall) begin  // see R8
          bit_d  = 4'h0;
          byte_d = 2'h0;
          if (rd_q) begin
            st_d   = TGT_TX;
            dout_d = snap_q[31];  // see R17
          end else begin
            st_d  = TGT_WAIT;
            drv_d = 1'h0;
          end
        end
        TGT_TX: if (scl_fall) begin  // see R4
          if (bit_q == `BYTE_BITS - 1) begin
            drv_d = 1'h0;
            st_d  = TGT_TX_ACK;
          end else begin
            bit_d  = bit_q + 4'h1;
            dout_d = pkt_bit(snap_q, byte_q, bit_q[2:0] + 3'h1);
          end
        end
        TGT_TX_ACK: if (scl_rise) begin
          if (sda_q || byte_q == 2'h3) st_d = TGT_WAIT;  // see R18
          else byte_d = byte_q + 2'h1;
        end else if (scl_fall && st_d == TGT_TX_ACK) begin
          st_d   = TGT_TX;
          bit_d  = 4'h0;
          drv_d  = 1'h1;
          dout_d = pkt_bit(snap_q, byte_q, 3'h0);
        end
        TGT_WAIT: drv_d = 1'h0;
        default: st_d = TGT_IDLE;
      endcase
    end
  end

  // State registers; all timing from sampled edges, any SCL rate well below the system clock works
  always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin  // see R3
    if (RST_IN) begin
      st_q <= TGT_IDLE;
      ms_q <= MEAS_IDLE;
      boot_q <= 32'h0;
      ready_q <= 1'h0;
      step_q <= 16'h0;
      addr_q <= `TGT_ADDR_DEFAULT;
      sh_q <= 8'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      rd_q <= 1'h0;
      drv_q <= 1'h0;
      dout_q <= 1'h1;
      snap_q <= 32'h0;
      press_q <= 14'h0;
      temp_q <= 11'h0;
      stat_q <= `STAT_STALE;
      pend_p_q <= 14'h0;
      pend_t_q <= 11'h0;
      pend_q <= 1'h0;
      req_q <= 1'h0;
      READY_OUT <= 1'h0;
      BUSY_OUT <= 1'h0;
    end else begin
      st_q <= st_d;
      ms_q <= ms_d;
      boot_q <= boot_d;
      ready_q <= ready_d;
      step_q <= step_d;
      addr_q <= addr_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      byte_q <= byte_d;
      rd_q <= rd_d;
      drv_q <= drv_d;
      dout_q <= dout_d;
      snap_q <= snap_d;
      press_q <= press_d;
      temp_q <= temp_d;
      stat_q <= stat_d;
      pend_p_q <= pend_p_d;
      pend_t_q <= pend_t_d;
      pend_q <= pend_d;
      req_q <= req_d;
      READY_OUT <= ready_d;
      BUSY_OUT <= (ms_d != MEAS_IDLE);
    end
  end

  // Open drain: only ever pulls low; enable low only while driving a zero
  assign bus.serial_data_line_tgt_out  = 1'h0;
  assign bus.serial_data_line_tgt_oe_n = ~(drv_q & ~dout_q);  // see R5
endmodule
